// file: rtl/ddrsq_pkg.sv
package ddrsq_pkg;
   // command encodings on the link (cs/ras/cas/we folded into a code)
   typedef enum logic [2:0] {
      DDRSQ_CMD_NOP  = 3'h0,
      DDRSQ_CMD_ACT  = 3'h1,
      DDRSQ_CMD_RD   = 3'h2,
      DDRSQ_CMD_RDA  = 3'h3,
      DDRSQ_CMD_WR   = 3'h4,
      DDRSQ_CMD_PRE  = 3'h5,
      DDRSQ_CMD_SREF = 3'h6,
      DDRSQ_CMD_SRX  = 3'h7
   } ddrsq_cmd_type;

   localparam int unsigned DDRSQ_DW    = 16;
   localparam int unsigned DDRSQ_BANKS = 8;
   localparam int unsigned DDRSQ_BAW   = 3;

   // latencies in clocks
   localparam logic [3:0] DDRSQ_AL   = 4'h2;
   localparam logic [3:0] DDRSQ_CL   = 4'h3;
   localparam logic [3:0] DDRSQ_RL   = DDRSQ_AL + DDRSQ_CL;
   localparam logic [3:0] DDRSQ_WL   = DDRSQ_RL - 4'h1;
   // data beats per burst, one per clock slot at single data rate on this model
   localparam logic [3:0] DDRSQ_BL4  = 4'h2;
   localparam logic [3:0] DDRSQ_BL8  = 4'h4;
   localparam int unsigned DDRSQ_PIPE = 16;

   // self refresh exit and termination timings, in ps and clocks
   localparam int unsigned DDRSQ_CLK_PS    = 8000;
   localparam int unsigned DDRSQ_TAOFD_PS  = 16000;
   localparam int unsigned DDRSQ_TXSNR_PS  = 200000;
   localparam int unsigned DDRSQ_TXSRD_CK  = 200;
   localparam int unsigned DDRSQ_TAOFD_CK  =
      (DDRSQ_TAOFD_PS + DDRSQ_CLK_PS - 1) / DDRSQ_CLK_PS;
   localparam int unsigned DDRSQ_TXSNR_CK  =
      (DDRSQ_TXSNR_PS + DDRSQ_CLK_PS - 1) / DDRSQ_CLK_PS;
   localparam int unsigned DDRSQ_CNTW      = 9;
endpackage

// file: rtl/ddrsq_link_if.sv
`timescale 1ns/10ps
interface ddrsq_link_if;
   import ddrsq_pkg::*;
   ddrsq_cmd_type          cmd;
   logic [DDRSQ_BAW-1:0]   bank;
   logic                   bl8;
   logic                   odt;
   logic [DDRSQ_DW-1:0]    wdata;
   logic                   wvalid;
   logic [DDRSQ_DW-1:0]    rdata;
   logic                   rvalid;

   modport device (input cmd, bank, bl8, odt, wdata, wvalid,
                   output rdata, rvalid);
   modport ctrl   (output cmd, bank, bl8, odt, wdata, wvalid,
                   input rdata, rvalid);
endinterface

// file: rtl/ddrsq_device.sv
`timescale 1ns/10ps
module ddrsq_device
   import ddrsq_pkg::*;
(
   // clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_rst_b,
   // link
   ddrsq_link_if.device               link,
   // user side: array data port
   input  wire logic [DDRSQ_DW-1:0]   i_rd_word,
   output logic      [DDRSQ_DW-1:0]   o_wr_word,
   output logic                       o_wr_strobe,
   output logic                       o_in_sref,
   output logic      [DDRSQ_BANKS-1:0] o_open_banks,
   output logic                       o_proto_err
);
   typedef enum logic [1:0] {
      DDRSQ_ST_IDLE = 2'b01,
      DDRSQ_ST_SREF = 2'b10
   } ddrsq_dst_type;

   ddrsq_dst_type            st_r;
   logic [DDRSQ_PIPE-1:0]    rd_pipe_r;
   logic [DDRSQ_PIPE-1:0]    wr_pipe_r;
   logic [DDRSQ_BANKS-1:0]   open_r;
   logic [DDRSQ_DW-1:0]      rdata_r;
   logic                     rvalid_r;
   logic                     err_r;
   logic [DDRSQ_DW-1:0]      wword_r;
   logic                     wstb_r;

   // beats of one burst as a mask of pipeline slots
   function automatic logic [DDRSQ_PIPE-1:0] burst_mask(input logic b8);
      burst_mask = b8 ? {{(DDRSQ_PIPE-4){1'b0}}, 4'hf}
                      : {{(DDRSQ_PIPE-2){1'b0}}, 2'h3};
   endfunction

   wire is_rd = (link.cmd == DDRSQ_CMD_RD) || (link.cmd == DDRSQ_CMD_RDA);
   wire is_wr = (link.cmd == DDRSQ_CMD_WR);

   ////////////////////////////////////////////////////////////////////////
   // read pipeline: bursts overlap by or-ing masks, so back to back
   // commands at burst spacing leave no hole in the data
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         rd_pipe_r <= '0;
      end else begin
         rd_pipe_r <= rd_pipe_r >> 1;
         if (is_rd && st_r == DDRSQ_ST_IDLE) begin
            // two slots less than RL: the same shift as writes (WL-1), as the output register adds the last clock
            rd_pipe_r <= (rd_pipe_r >> 1)
                         | (burst_mask(link.bl8) << (DDRSQ_RL - 4'h2));
         end
      end
   end

   // write pipeline: wdata sampled at WL, one clock before read data shows
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         wr_pipe_r <= '0;
      end else begin
         wr_pipe_r <= wr_pipe_r >> 1;
         if (is_wr && st_r == DDRSQ_ST_IDLE) begin
            wr_pipe_r <= (wr_pipe_r >> 1)
                         | (burst_mask(link.bl8) << (DDRSQ_WL - 4'h1));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data out, registered
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
      end else begin
         rvalid_r <= rd_pipe_r[0];
         rdata_r  <= rd_pipe_r[0] ? i_rd_word : '0;
      end
   end

   // write data capture while a write slot is due
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         wstb_r  <= 1'b0;
         wword_r <= '0;
      end else begin
         wstb_r  <= wr_pipe_r[0] && link.wvalid;
         if (wr_pipe_r[0]) begin
            wword_r <= link.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bank state and self refresh; misuse in idle is flagged but still carried out; in self refresh all but SRX is ignored
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         open_r <= '0;
         st_r   <= DDRSQ_ST_IDLE;
         err_r  <= 1'b0;
      end else begin
         case (st_r)
            DDRSQ_ST_IDLE: begin
               case (link.cmd)
                  DDRSQ_CMD_ACT: open_r[link.bank] <= 1'b1;
                  DDRSQ_CMD_PRE: open_r[link.bank] <= 1'b0;
                  DDRSQ_CMD_RDA: begin
                     if (!open_r[link.bank]) err_r <= 1'b1;
                     open_r[link.bank] <= 1'b0;
                  end
                  DDRSQ_CMD_RD, DDRSQ_CMD_WR: begin
                     if (!open_r[link.bank]) err_r <= 1'b1;
                  end
                  DDRSQ_CMD_SREF: begin
                     if (open_r != '0 || link.odt) err_r <= 1'b1;
                     st_r <= DDRSQ_ST_SREF;
                  end
                  default: ;
               endcase
            end
            DDRSQ_ST_SREF: begin
               if (link.cmd == DDRSQ_CMD_SRX) st_r <= DDRSQ_ST_IDLE;
            end
            default: st_r <= DDRSQ_ST_IDLE;
         endcase
      end
   end

   assign link.rdata   = rdata_r;
   assign link.rvalid  = rvalid_r;
   assign o_wr_word    = wword_r;
   assign o_wr_strobe  = wstb_r;
   assign o_in_sref    = st_r[1]; // one-hot bit of the self refresh state
   assign o_open_banks = open_r;
   assign o_proto_err  = err_r;
endmodule

// file: rtl/ddrsq_ctrl.sv
`timescale 1ns/10ps
module ddrsq_ctrl
   import ddrsq_pkg::*;
(
   // clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_rst_b,
   // link
   ddrsq_link_if.ctrl                 link,
   // user request: command held until accepted
   input  wire logic                  i_req,
   input  wire ddrsq_cmd_type         i_cmd,
   input  wire logic [DDRSQ_BAW-1:0]  i_bank,
   input  wire logic                  i_bl8,
   input  wire logic                  i_odt_want,
   input  wire logic [DDRSQ_DW-1:0]   i_wdata,
   input  wire logic                  i_wvalid,
   output logic                       o_ack,
   // user read data
   output logic      [DDRSQ_DW-1:0]   o_rdata,
   output logic                       o_rvalid
);
   logic [DDRSQ_CNTW-1:0]  xsrd_r;
   logic [DDRSQ_CNTW-1:0]  xsnr_r;
   logic [DDRSQ_CNTW-1:0]  aofd_r;
   logic [DDRSQ_CNTW-1:0]  gap_r;
   logic [DDRSQ_BANKS-1:0] open_r;
   logic                   sref_r;
   logic                   odt_r;
   logic                   ack_r;
   ddrsq_cmd_type          cmd_r;
   logic [DDRSQ_BAW-1:0]   bank_r;
   logic                   bl8_r;
   logic [DDRSQ_DW-1:0]    rd_r;
   logic                   rv_r;
   logic                   ok;

   wire req_rd = (i_cmd == DDRSQ_CMD_RD) || (i_cmd == DDRSQ_CMD_RDA);
   wire req_rw = req_rd || (i_cmd == DDRSQ_CMD_WR);

   ////////////////////////////////////////////////////////////////////////
   // gate each request on the timers and bank state
   always_comb begin
      ok = 1'b1;
      if (sref_r) ok = (i_cmd == DDRSQ_CMD_SRX);
      else if (req_rd && xsrd_r != '0) ok = 1'b0;
      else if (!req_rd && xsnr_r != '0 && i_cmd != DDRSQ_CMD_NOP)
         ok = 1'b0;
      if (req_rw && (gap_r != '0 || !open_r[i_bank])) ok = 1'b0;
      if (i_cmd == DDRSQ_CMD_SREF && (open_r != '0 || odt_r
          || aofd_r != '0)) ok = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // command issue and bank tracking
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         cmd_r  <= DDRSQ_CMD_NOP;
         bank_r <= '0;
         bl8_r  <= 1'b0;
         ack_r  <= 1'b0;
         open_r <= '0;
         sref_r <= 1'b0;
      end else begin
         cmd_r <= DDRSQ_CMD_NOP;
         ack_r <= 1'b0;
         if (i_req && ok && !ack_r) begin
            cmd_r  <= i_cmd;
            bank_r <= i_bank;
            bl8_r  <= i_bl8;
            ack_r  <= 1'b1;
            case (i_cmd)
               DDRSQ_CMD_ACT:  open_r[i_bank] <= 1'b1;
               DDRSQ_CMD_PRE,
               DDRSQ_CMD_RDA:  open_r[i_bank] <= 1'b0;
               DDRSQ_CMD_SREF: sref_r <= 1'b1;
               DDRSQ_CMD_SRX:  sref_r <= 1'b0;
               default: ;
            endcase
         end
      end
   end

   // burst spacing: 2 clocks at bl4, 4 at bl8 keeps data gapless
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         gap_r <= '0;
      end else if (i_req && ok && !ack_r && req_rw) begin
         // holds off beats-1 edges, so the next rd/wr lands beats clocks later
         gap_r <= DDRSQ_CNTW'(i_bl8 ? DDRSQ_BL8 - 4'h1 : DDRSQ_BL4 - 4'h1);
      end else if (gap_r != '0) begin
         gap_r <= gap_r - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // exit timers start on the exit command; termination timer on an odt drop not caused by ack_r alone
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         xsrd_r <= '0;
         xsnr_r <= '0;
      end else if (i_req && ok && !ack_r && i_cmd == DDRSQ_CMD_SRX) begin
         xsrd_r <= DDRSQ_CNTW'(DDRSQ_TXSRD_CK);
         xsnr_r <= DDRSQ_CNTW'(DDRSQ_TXSNR_CK);
      end else begin
         if (xsrd_r != '0) xsrd_r <= xsrd_r - 1'b1;
         if (xsnr_r != '0) xsnr_r <= xsnr_r - 1'b1;
      end
   end

   // termination held off in self refresh and until tXSRD expires
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         odt_r  <= 1'b0;
         aofd_r <= '0;
      end else begin
         odt_r <= i_odt_want && !sref_r && xsrd_r == '0 && !ack_r;
         if (odt_r && !(i_odt_want && !sref_r && xsrd_r == '0))
            aofd_r <= DDRSQ_CNTW'(DDRSQ_TAOFD_CK);
         else if (aofd_r != '0)
            aofd_r <= aofd_r - 1'b1;
      end
   end

   // read data registered to the user
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         rd_r <= '0;
         rv_r <= 1'b0;
      end else begin
         rd_r <= link.rdata;
         rv_r <= link.rvalid;
      end
   end

   assign link.cmd    = cmd_r;
   assign link.bank   = bank_r;
   assign link.bl8    = bl8_r;
   assign link.odt    = odt_r;
   assign link.wdata  = i_wdata;  // data timed by the user at WL
   assign link.wvalid = i_wvalid;
   assign o_ack       = ack_r;
   assign o_rdata     = rd_r;
   assign o_rvalid    = rv_r;
endmodule

// file: dv/ddrsq_chk.sv
`timescale 1ns/10ps
module ddrsq_chk
   import ddrsq_pkg::*;
(
   // clock and reset
   input  wire logic          i_clock,
   input  wire logic          i_rst_b,
   // link signals
   input  wire ddrsq_cmd_type cmd,
   input  wire logic          bl8,
   input  wire logic          odt,
   input  wire logic          rvalid
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   logic                  is_rd;
   logic                  is_rw;
   logic [DDRSQ_CNTW-1:0] srx_age_r;
   assign is_rd = cmd == DDRSQ_CMD_RD || cmd == DDRSQ_CMD_RDA;
   assign is_rw = is_rd || cmd == DDRSQ_CMD_WR;
   ////////////////////////////////////////////////////////////////////////////
   // clocks since exit; saturates so a run without an exit never blocks
   always_ff @(posedge i_clock) begin
      if (!i_rst_b)
         srx_age_r <= '1;
      else if (cmd == DDRSQ_CMD_SRX)
         srx_age_r <= 9'h001;
      else if (srx_age_r != '1)
         srx_age_r <= srx_age_r + 9'h001;
   end
   ////////////////////////////////////////////////////////////////////////////
   a_read_lat_short: assert property (is_rd && !bl8 |-> ##5 rvalid[*2])
      else $error("short read data not at read latency");
   a_read_lat_long: assert property (is_rd && bl8 |-> ##5 rvalid[*4])
      else $error("long read data not at read latency");
   a_read_no_early: assert property ($rose(rvalid) |-> $past(is_rd, 5))
      else $error("read data without a read five clocks before");
   a_cmd_spacing: assert property (cmd != DDRSQ_CMD_NOP |=>
      cmd == DDRSQ_CMD_NOP) else $error("commands closer than two clocks");
   a_long_gap: assert property (is_rw && bl8 |=> (!is_rw)[*3])
      else $error("long burst followed too soon");
   a_sref_odt_off: assert property (cmd == DDRSQ_CMD_SREF |->
      !odt && !$past(odt) && !$past(odt, 2))
      else $error("self refresh entered with termination recently on");
   a_exit_read: assert property (is_rd |-> srx_age_r >= DDRSQ_TXSRD_CK)
      else $error("read too soon after self refresh exit");
   a_exit_other: assert property (cmd != DDRSQ_CMD_NOP && !is_rd &&
      cmd != DDRSQ_CMD_SRX |-> srx_age_r >= DDRSQ_TXSNR_CK)
      else $error("command too soon after self refresh exit");
   a_exit_odt: assert property (odt |-> srx_age_r >= DDRSQ_TXSRD_CK)
      else $error("termination on too soon after self refresh exit");
   c_long_read: cover property (is_rd && bl8);
   c_write: cover property (cmd == DDRSQ_CMD_WR);
   c_exit: cover property (cmd == DDRSQ_CMD_SRX);
endmodule

// file: dv/ddr2_burst_and_self_refresh_sequencing_bench.sv
`timescale 1ns/10ps
module ddr2_burst_and_self_refresh_sequencing_bench;
   import ddrsq_pkg::*;
   logic                 i_clock = 1'b0;
   logic                 i_rst_b = 1'b0;
   logic                 req = 1'b0;
   ddrsq_cmd_type        cmd = DDRSQ_CMD_NOP;
   logic [DDRSQ_BAW-1:0] bank = 3'h0;
   logic                 bl8 = 1'b0;
   logic                 odt_want = 1'b0;
   logic [DDRSQ_DW-1:0]  wdata = 16'h0000;
   logic                 wvalid = 1'b0;
   logic [DDRSQ_DW-1:0]  rd_word = 16'h0000;
   logic [DDRSQ_DW-1:0]  rdata, wr_word, rd_q[$], wr_q[$], wd_q[$];
   logic [7:0]           open_banks;
   logic                 ack, rvalid, wr_strobe, in_sref, proto_err;
   int                   wt_q[$];
   int                   bad_count = 0;
   int                   n_checks = 0;
   int                   cyc = 0;
   int                   t0, t1;
   logic [31:0]          seed = 32'h0000e6e6;
   ddrsq_link_if link ();
   ddrsq_ctrl u_ddrsq_ctrl (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .link(link.ctrl), .i_req(req), .i_cmd(cmd), .i_bank(bank), .i_bl8(bl8),
      .i_odt_want(odt_want), .i_wdata(wdata), .i_wvalid(wvalid), .o_ack(ack),
      .o_rdata(rdata), .o_rvalid(rvalid));
   ddrsq_device u_ddrsq_device (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .link(link.device), .i_rd_word(rd_word), .o_wr_word(wr_word),
      .o_wr_strobe(wr_strobe), .o_in_sref(in_sref),
      .o_open_banks(open_banks), .o_proto_err(proto_err));
   ddrsq_chk u_ddrsq_chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .cmd(link.cmd), .bl8(link.bl8), .odt(link.odt), .rvalid(link.rvalid));
   ////////////////////////////////////////////////////////////////////////////
   // free-running clock and an edge count for scheduling write beats
   always #4 i_clock = ~i_clock;
   always @(posedge i_clock) cyc <= cyc + 1;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // req stays up between calls so back-to-back commands keep min spacing
   task automatic issue(input ddrsq_cmd_type c, input logic [2:0] b,
                        input logic l);
      int n;
      cmd = c;
      bank = b;
      bl8 = l;
      req = 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         #1;
         n++;
         if (n > 400) begin
            chk("ack wait", 1, 0);
            print_verdict();
         end
      end while (ack !== 1'b1);
      t0 = cyc;
      for (int k = 0; k < (l ? 4 : 2); k++) begin
         seed = xs(seed);
         if (c == DDRSQ_CMD_WR) begin
            wd_q.push_back(seed[15:0]);
            wr_q.push_back(seed[15:0]);
            wt_q.push_back(cyc + 4 + k);
         end
         if (c == DDRSQ_CMD_RD || c == DDRSQ_CMD_RDA)
            rd_q.push_back(rd_word);
      end
   endtask
   task automatic idle(input int n);
      req = 1'b0;
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // write beats go out one write latency after the command hits the link
   always @(posedge i_clock) begin
      #1;
      if (wt_q.size() > 0 && wt_q[0] == cyc) begin
         wvalid = 1'b1;
         wdata = wd_q.pop_front();
         void'(wt_q.pop_front());
      end else
         wvalid = 1'b0;
   end
   // compare each delivered beat with the oldest expected one
   always @(posedge i_clock) begin
      if (rvalid === 1'b1)
         chk("rdata", rd_q.size() ? rd_q.pop_front() : 16'hdead, rdata);
      if (wr_strobe === 1'b1)
         chk("wr_word", wr_q.size() ? wr_q.pop_front() : 16'hdead, wr_word);
   end
   ////////////////////////////////////////////////////////////////////////////
   // main sequence: bursts, refusal, self refresh entry and exit
   initial begin
      repeat (16) @(posedge i_clock);
      #1;
      i_rst_b = 1'b1;
      issue(DDRSQ_CMD_ACT, 3'h0, 1'b0);
      issue(DDRSQ_CMD_ACT, 3'h3, 1'b0);
      idle(3);
      chk("open banks", 8'h09, open_banks);
      rd_word = seed[15:0];
      issue(DDRSQ_CMD_RD, 3'h0, 1'b0);
      issue(DDRSQ_CMD_RD, 3'h3, 1'b0);
      issue(DDRSQ_CMD_RD, 3'h3, 1'b1);
      issue(DDRSQ_CMD_RD, 3'h0, 1'b1);
      idle(16);
      odt_want = 1'b1;
      issue(DDRSQ_CMD_WR, 3'h3, 1'b0);
      issue(DDRSQ_CMD_WR, 3'h0, 1'b0);
      issue(DDRSQ_CMD_WR, 3'h0, 1'b1);
      issue(DDRSQ_CMD_WR, 3'h3, 1'b1);
      idle(16);
      issue(DDRSQ_CMD_RDA, 3'h3, 1'b0);
      idle(16);
      chk("open banks", 8'h01, open_banks);
      cmd = DDRSQ_CMD_SREF;
      req = 1'b1;
      repeat (12) begin
         @(posedge i_clock);
         #1;
         chk("refused ack", 0, ack);
      end
      idle(1);
      issue(DDRSQ_CMD_PRE, 3'h0, 1'b0);
      odt_want = 1'b0;
      issue(DDRSQ_CMD_SREF, 3'h0, 1'b0);
      idle(3);
      chk("in sref", 1, in_sref);
      chk("proto err", 0, proto_err);
      issue(DDRSQ_CMD_SRX, 3'h0, 1'b0);
      t1 = t0;
      odt_want = 1'b1;
      issue(DDRSQ_CMD_ACT, 3'h0, 1'b0);
      chk("act gap ok", 1, t0 - t1 >= DDRSQ_TXSNR_CK);
      issue(DDRSQ_CMD_RD, 3'h0, 1'b1);
      chk("read gap ok", 1, t0 - t1 >= DDRSQ_TXSRD_CK);
      idle(16);
      chk("beats left", 0, rd_q.size() + wr_q.size());
      print_verdict();
   end
endmodule
